/* File: rtl/ffc_unit.sv */
`timescale 1ns/10ps
module ffc_unit
  import ffc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic op_valid,
  input wire logic op_to_fixed,
  input wire logic [1:0] fixed_point_type,
  input wire logic [5:0] op_fbits,
  input wire logic [31:0] single_dest_register,
  input wire logic op_privileged,
  input wire logic [3:0] flags_in,
  output logic res_valid,
  output logic [31:0] res_data,
  output logic [3:0] flags_out,
  output logic no_coprocessor_fault,
  output logic irq
);
  typedef struct packed {
    logic [31:0] coprocessor_access_privileges;
    logic [FFC_ST_W-1:0] status;
    logic [FFC_ST_W-1:0] enable;
    logic dp_active;
    logic dp_write;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
    logic res_valid;
    logic [31:0] res_data;
    logic [3:0] flags;
    logic fault;
  } ffc_state_type;

  ffc_state_type state_reg;
  ffc_state_type state_next;
  logic [31:0] to_fixed_res;
  logic [31:0] to_float_res;
  logic [1:0] prim_field;
  logic [1:0] sec_field;
  logic allowed;
  logic take;
  logic [FFC_ST_W-1:0] events;
  logic [FFC_ST_W-1:0] clear_bits;
  // conversion result and access decisions
  logic [31:0] conv_res;
  logic prim_ok;
  logic sec_ok;
  logic op_accept;
  logic op_refuse;
  // bus decode in address and data phase
  logic take_read;
  logic [11:0] ap_off;
  logic dp_wr;
  logic wr_access;
  logic wr_clear;
  logic wr_enable;
  logic [31:0] rd_word;
  logic [31:0] access_wr_value;
  // per-bit sticky status and interrupt terms
  logic [FFC_ST_W-1:0] status_set;
  logic [FFC_ST_W-1:0] irq_bits;

  ffc_float_to_fixed u_to_fixed (
    .fp_in(single_dest_register),
    .fixed_type(fixed_point_type),
    .fbits(op_fbits),
    .fix_out(to_fixed_res)
  );

  ffc_fixed_to_float u_to_float (
    .fix_in(single_dest_register),
    .fixed_type(fixed_point_type),
    .fbits(op_fbits),
    .fp_out(to_float_res)
  );

  // privilege check against both access fields
  function automatic logic field_ok(input logic [1:0] f, input logic priv);
    logic ok;
    ok = 1'b0;
    unique case (f)
      FFC_ACC_DENIED: begin
        ok = 1'b0;
      end
      FFC_ACC_PRIV: begin
        ok = priv;
      end
      FFC_ACC_FULL: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0; // reserved value treated as denied
      end
    endcase
    return ok;
  endfunction : field_ok

  // access fields; both must permit the op
  always_comb begin
    prim_field = state_reg.coprocessor_access_privileges[FFC_PRIMARY_LSB +: 2];
    sec_field = state_reg.coprocessor_access_privileges[FFC_SECONDARY_LSB +: 2];
    prim_ok = field_ok(prim_field, op_privileged);
    sec_ok = field_ok(sec_field, op_privileged);
    allowed = prim_ok && sec_ok;
    op_accept = op_valid && allowed;
    op_refuse = op_valid && !allowed;
  end

  // result by direction
  always_comb begin
    if (op_to_fixed) begin
      conv_res = to_fixed_res;
    end else begin
      conv_res = to_float_res;
    end
  end

  // address phase decode
  always_comb begin
    take = hsel && hready && htrans[1];
    take_read = take && !hwrite;
    ap_off = haddr[11:0];
  end

  // data phase decode of the pending write
  always_comb begin
    dp_wr = state_reg.dp_active && state_reg.dp_write;
    wr_access = dp_wr && (state_reg.dp_addr == FFC_ACCESS_OFF);
    wr_clear = dp_wr && (state_reg.dp_addr == FFC_CLEAR_OFF);
    wr_enable = dp_wr && (state_reg.dp_addr == FFC_ENABLE_OFF);
    // reserved bits never stored
    access_wr_value = hwdata & FFC_ACCESS_MASK;
  end

  // read word; clear register and holes read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (ap_off)
      FFC_ACCESS_OFF: begin
        rd_word = state_reg.coprocessor_access_privileges;
      end
      FFC_STATUS_OFF: begin
        rd_word[FFC_ST_W-1:0] = state_reg.status;
      end
      FFC_ENABLE_OFF: begin
        rd_word[FFC_ST_W-1:0] = state_reg.enable;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // events from the conversion port, clears from the bus
  always_comb begin
    events = '0;
    events[FFC_ST_DONE] = op_accept;
    events[FFC_ST_FAULT] = op_refuse;
    clear_bits = '0;
    if (wr_clear) begin
      clear_bits = hwdata[FFC_ST_W-1:0];
    end
  end

  // sticky status per bit, set wins over clear
  for (genvar i = 0; i < FFC_ST_W; i++) begin : g_status
    assign status_set[i] = events[i] | (state_reg.status[i] & ~clear_bits[i]);
    assign irq_bits[i] = state_reg.status[i] & state_reg.enable[i];
  end

  // next state: answer, registers, bus capture
  always_comb begin
    state_next = state_reg;
    // answer one cycle after issue, one pulse
    state_next.res_valid = op_accept;
    state_next.fault = op_refuse;
    // flags pass through untouched
    if (op_valid) begin
      state_next.flags = flags_in;
    end
    // result held until the next accepted op
    if (op_accept) begin
      state_next.res_data = conv_res;
    end
    // register writes in the data phase
    if (wr_access) begin
      state_next.coprocessor_access_privileges = access_wr_value;
    end
    if (wr_enable) begin
      state_next.enable = hwdata[FFC_ST_W-1:0];
    end
    state_next.status = status_set;
    // address phase capture for the next data phase
    state_next.dp_active = take;
    state_next.dp_write = hwrite;
    state_next.dp_addr = ap_off;
    // read data launched for the data phase
    if (take_read) begin
      state_next.rdata = rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.coprocessor_access_privileges <= FFC_ACCESS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign res_valid = state_reg.res_valid;
  assign res_data = state_reg.res_data;
  assign flags_out = state_reg.flags;
  assign no_coprocessor_fault = state_reg.fault;
  assign irq = |irq_bits;
endmodule : ffc_unit

/* File: shared/ffc_pkg.sv */
package ffc_pkg;
  // register byte offsets
  localparam logic [11:0] FFC_ACCESS_OFF = 12'h000;
  localparam logic [11:0] FFC_STATUS_OFF = 12'h004;
  localparam logic [11:0] FFC_CLEAR_OFF = 12'h008;
  localparam logic [11:0] FFC_ENABLE_OFF = 12'h00C;
  // access field positions
  localparam int FFC_PRIMARY_LSB = 20;
  localparam int FFC_SECONDARY_LSB = 22;
  localparam logic [31:0] FFC_ACCESS_MASK = 32'h00F0_0000;
  localparam logic [31:0] FFC_ACCESS_RESET = 32'h0000_0000;
  // access field values
  localparam logic [1:0] FFC_ACC_DENIED = 2'h0;
  localparam logic [1:0] FFC_ACC_PRIV = 2'h1;
  localparam logic [1:0] FFC_ACC_FULL = 2'h3;
  // status bits
  localparam int FFC_ST_DONE = 0;
  localparam int FFC_ST_FAULT = 1;
  localparam int FFC_ST_W = 2;
  // fixed-point type encodings
  typedef enum logic [1:0] {
    FFC_S16 = 2'b00,
    FFC_U16 = 2'b01,
    FFC_S32 = 2'b10,
    FFC_U32 = 2'b11
  } ffc_fixed_type;
endpackage : ffc_pkg

/* File: rtl/ffc_float_to_fixed.sv */
`timescale 1ns/10ps
// float to fixed, round toward zero, saturating
module ffc_float_to_fixed
  import ffc_pkg::*;
(
  input wire logic [31:0] fp_in,
  input wire logic [1:0] fixed_type,
  input wire logic [5:0] fbits,
  output logic [31:0] fix_out
);
  logic sign;
  logic [7:0] exp_f;
  logic [23:0] mant;
  logic [63:0] mag;
  logic [31:0] lim;
  logic [31:0] res;
  logic is_signed;
  logic wide;
  int sh;
  always_comb begin
    sign = fp_in[31];
    exp_f = fp_in[30:23];
    mant = {(exp_f != 8'h00), fp_in[22:0]};
    is_signed = ~fixed_type[0];
    wide = fixed_type[1];
    // value * 2^fbits = mant * 2^(exp-150+fbits); dropped bits truncate toward zero
    sh = int'(exp_f) - 150 + int'(fbits);
    if (exp_f == 8'hFF) begin
      mag = 64'hFFFF_FFFF_FFFF_FFFF;
    end else if (sh >= 40) begin
      mag = 64'hFFFF_FFFF_FFFF_FFFF;
    end else if (sh >= 0) begin
      mag = {40'h00_0000_0000, mant} << sh;
    end else if (sh > -24) begin
      mag = {40'h00_0000_0000, mant} >> (-sh);
    end else begin
      mag = 64'h0;
    end
    if (wide) lim = is_signed ? (sign ? 32'h8000_0000 : 32'h7FFF_FFFF) : 32'hFFFF_FFFF;
    else lim = is_signed ? (sign ? 32'h0000_8000 : 32'h0000_7FFF) : 32'h0000_FFFF;
    if (fp_in[30:0] > 31'h7F80_0000) begin
      res = 32'h0; // nan
    end else if (~is_signed && sign) begin
      res = 32'h0;
    end else if (mag > {32'h0, lim}) begin
      res = lim;
    end else begin
      res = mag[31:0];
    end
    if (sign && is_signed) res = 32'h0 - res;
    // extend to register width
    if (!wide) begin
      fix_out = is_signed ? {{16{res[15]}}, res[15:0]} : {16'h0000, res[15:0]};
    end else begin
      fix_out = res;
    end
  end
endmodule : ffc_float_to_fixed

/* File: rtl/ffc_fixed_to_float.sv */
`timescale 1ns/10ps
// fixed to float, round to nearest even
module ffc_fixed_to_float
  import ffc_pkg::*;
(
  input wire logic [31:0] fix_in,
  input wire logic [1:0] fixed_type,
  input wire logic [5:0] fbits,
  output logic [31:0] fp_out
);
  logic is_signed;
  logic sign;
  logic [31:0] op;
  logic [31:0] mag;
  logic [31:0] norm;
  logic [24:0] rmant;
  logic guard;
  logic sticky;
  int lead;
  int e;
  always_comb begin
    is_signed = ~fixed_type[0];
    // for 16-bit types only the low 16 bits of the source are used
    op = fixed_type[1] ? fix_in : (is_signed ? {{16{fix_in[15]}}, fix_in[15:0]}
                                             : {16'h0000, fix_in[15:0]});
    sign = is_signed & op[31];
    mag = sign ? 32'h0 - op : op;
    lead = 0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) lead = i;
    end
    norm = mag << (31 - lead);
    guard = norm[7];
    sticky = |norm[6:0];
    rmant = {1'b0, norm[31:8]};
    if (guard && (sticky || norm[8])) rmant = rmant + 25'h1;
    e = lead + 127 - int'(fbits);
    if (rmant[24]) begin
      e = e + 1;
      rmant = rmant >> 1;
    end
    if (mag == 32'h0) begin
      fp_out = 32'h0;
    end else if (e <= 0) begin
      fp_out = {sign, 31'h0}; // below normal range flushes to zero
    end else begin
      fp_out = {sign, e[7:0], rmant[22:0]};
    end
  end
endmodule : ffc_fixed_to_float

/* File: testbench/ffc_props.sv */
`timescale 1ns/10ps
module ffc_props
  import ffc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic op_valid,
  input wire logic op_to_fixed,
  input wire logic [1:0] fixed_point_type,
  input wire logic [31:0] single_dest_register,
  input wire logic [3:0] flags_in,
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  input wire logic [3:0] flags_out,
  input wire logic no_coprocessor_fault,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // each op answers once, next cycle
  property p_flags; op_valid |=> flags_out == $past(flags_in); endproperty
  a_flags: assert property (p_flags) else $error("flags changed");
  property p_one; op_valid |=> res_valid != no_coprocessor_fault; endproperty
  a_one: assert property (p_one) else $error("no single answer");
  property p_idle; !op_valid |=> !res_valid && !no_coprocessor_fault; endproperty
  a_idle: assert property (p_idle) else $error("answer without op");
  // width extension of 16-bit results, zero source to float stays zero
  property p_sext; op_valid && op_to_fixed && fixed_point_type == FFC_S16
    |=> !res_valid || res_data[31:16] == {16{res_data[15]}}; endproperty
  a_sext: assert property (p_sext) else $error("no sign extension");
  property p_zext; op_valid && op_to_fixed && fixed_point_type == FFC_U16
    |=> !res_valid || res_data[31:16] == 16'h0000; endproperty
  a_zext: assert property (p_zext) else $error("no zero extension");
  property p_zero; op_valid && !op_to_fixed && single_dest_register == 32'h0
    |=> !res_valid || res_data == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("zero not kept");
  // bus and interrupt
  property p_resp; hreadyout && !hresp; endproperty
  a_resp: assert property (p_resp) else $error("bus not ready");
  property p_irq; $rose(irq) |-> $past(op_valid) || $past(hsel) || $past(hsel, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : ffc_props
bind ffc_unit ffc_props u_props (.hclk, .hresetn, .hsel, .hreadyout, .hresp, .op_valid,
  .op_to_fixed, .fixed_point_type, .single_dest_register, .flags_in, .res_valid,
  .res_data, .flags_out, .no_coprocessor_fault, .irq);

/* File: testbench/ffc_core_model.sv */
`timescale 1ns/10ps
module ffc_core_model (
  input wire logic hclk,
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  input wire logic no_coprocessor_fault,
  output logic op_valid,
  output logic op_to_fixed,
  output logic [1:0] fixed_point_type,
  output logic [5:0] op_fbits,
  output logic [31:0] single_dest_register,
  output logic op_privileged,
  output logic [3:0] flags_in
);
  initial begin
    {op_valid, op_to_fixed, fixed_point_type, op_fbits, op_privileged} <= '0;
    {single_dest_register, flags_in} <= '0;
  end
  // one issue cycle, answer taken next cycle
  task issue(input logic tf, input logic [1:0] ty, input logic [5:0] fb, input logic pv,
    input logic [31:0] d, output logic [33:0] r);
    @(posedge hclk);
    op_valid <= 1'b1;
    {op_to_fixed, fixed_point_type, op_fbits} <= {tf, ty, fb};
    {op_privileged, single_dest_register} <= {pv, d};
    flags_in <= fb[3:0] ^ 4'hA;
    @(posedge hclk);
    op_valid <= 1'b0;
    single_dest_register <= ~d; // operand gone after issue
    #1 r = {res_valid, no_coprocessor_fault, res_data};
  endtask : issue
endmodule : ffc_core_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench
  import ffc_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, res_data, single_dest_register, q;
  logic [1:0] htrans = '0, fixed_point_type;
  logic [2:0] hsize = 3'h2;
  logic [5:0] op_fbits;
  logic [3:0] flags_in, flags_out;
  logic [33:0] r;
  logic hreadyout, hresp, op_valid, op_to_fixed, op_privileged, res_valid, fault, irq;
  int bad_count = 0, total_checks = 0;
  always #5 hclk = ~hclk;
  ffc_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_valid, .op_to_fixed,
    .fixed_point_type, .op_fbits, .single_dest_register, .op_privileged, .flags_in,
    .res_valid, .res_data, .flags_out, .no_coprocessor_fault(fault), .irq);
  ffc_core_model u_core (.hclk, .res_valid, .res_data, .no_coprocessor_fault(fault),
    .op_valid, .op_to_fixed, .fixed_point_type, .op_fbits, .single_dest_register,
    .op_privileged, .flags_in);
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // wait for hready under a bound
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      test_done;
    end
  endtask : wt
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
    haddr <= {20'h00000, a};
    wt;
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    wt;
    #1 q = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask : bus
  task op(input logic tf, input logic [1:0] ty, input logic [5:0] fb, input logic pv,
    input logic [31:0] d, input logic flt, input logic [31:0] e);
    u_core.issue(tf, ty, fb, pv, d, r);
    chk("flags", flags_out, fb[3:0] ^ 4'hA);
    if (flt) chk("fault", r[33:32], 2'h1);
    else chk("result", r, {2'h2, e});
  endtask : op
  task t_reset;
    bus(1'b0, FFC_ACCESS_OFF, 32'h0);
    chk("access reset", q, FFC_ACCESS_RESET);
    op(1'b1, FFC_S32, 6'h01, 1'b1, 32'h3F80_0000, 1'b1, 32'h0);
  endtask : t_reset
  task t_regs;
    bus(1'b1, FFC_ACCESS_OFF, 32'hFFFF_FFFF);
    bus(1'b0, FFC_ACCESS_OFF, 32'h0);
    chk("access all", q, 32'h00F0_0000);
    bus(1'b0, 12'h010, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, FFC_ACCESS_OFF, 32'h0030_0000);
    bus(1'b0, FFC_ACCESS_OFF, 32'h0);
    chk("access part", q, 32'h0030_0000);
    bus(1'b1, FFC_ACCESS_OFF, 32'h00F0_0000);
  endtask : t_regs
  // every type and both directions, unprivileged under full access
  task t_convert;
    op(1'b1, FFC_S32, 6'h01, 1'b0, 32'h4030_0000, 1'b0, 32'h0000_0005);
    op(1'b1, FFC_S32, 6'h01, 1'b0, 32'hC030_0000, 1'b0, 32'hFFFF_FFFB);
    op(1'b1, FFC_S16, 6'h00, 1'b0, 32'hBF80_0000, 1'b0, 32'hFFFF_FFFF);
    op(1'b1, FFC_U16, 6'h04, 1'b0, 32'h3FC0_0000, 1'b0, 32'h0000_0018);
    op(1'b1, FFC_U32, 6'h01, 1'b0, 32'h4030_0000, 1'b0, 32'h0000_0005);
    op(1'b0, FFC_S16, 6'h00, 1'b0, 32'hABCD_0003, 1'b0, 32'h4040_0000);
    op(1'b0, FFC_U16, 6'h10, 1'b0, 32'h0000_8000, 1'b0, 32'h3F00_0000);
    op(1'b0, FFC_S32, 6'h01, 1'b0, 32'hFFFF_FFFC, 1'b0, 32'hC000_0000);
    op(1'b0, FFC_U32, 6'h01, 1'b0, 32'h0200_0003, 1'b0, 32'h4B80_0001);
  endtask : t_convert
  task t_priv;
    bus(1'b1, FFC_ACCESS_OFF, 32'h0050_0000);
    op(1'b1, FFC_S32, 6'h01, 1'b0, 32'h4030_0000, 1'b1, 32'h0);
    op(1'b1, FFC_S32, 6'h01, 1'b1, 32'h4030_0000, 1'b0, 32'h0000_0005);
    bus(1'b1, FFC_ACCESS_OFF, 32'h0000_0000);
    op(1'b1, FFC_S32, 6'h01, 1'b1, 32'h4030_0000, 1'b1, 32'h0);
  endtask : t_priv
  // sticky status, clear, enable and mask
  task t_irq;
    bus(1'b0, FFC_STATUS_OFF, 32'h0);
    chk("status sticky", q, 32'h3);
    bus(1'b1, FFC_CLEAR_OFF, 32'h3);
    bus(1'b0, FFC_STATUS_OFF, 32'h0);
    chk("status clear", q, 32'h0);
    bus(1'b1, FFC_ENABLE_OFF, 32'h3);
    chk("irq idle", irq, 1'b0);
    op(1'b1, FFC_U32, 6'h01, 1'b1, 32'h3F80_0000, 1'b1, 32'h0);
    chk("irq set", irq, 1'b1);
    bus(1'b0, FFC_STATUS_OFF, 32'h0);
    chk("status fault", q, 32'h2);
    bus(1'b1, FFC_ENABLE_OFF, 32'h1);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, FFC_ENABLE_OFF, 32'h2);
    chk("irq unmasked", irq, 1'b1);
    bus(1'b1, FFC_CLEAR_OFF, 32'h2);
    chk("irq cleared", irq, 1'b0);
  endtask : t_irq
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_convert;
    t_priv;
    t_irq;
    test_done;
  end
endmodule : testbench
